// ### hsd_map.svh
// hsd_map.svh : offsets, field positions, reset values and timing counts
// assumes inclusion by the package and both design modules only
`ifndef HSD_MAP_SVH
`define HSD_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define HSD_ADDR_CONF0   4'h0
`define HSD_ADDR_CONF1   4'h1
`define HSD_ADDR_GCR     4'h2
`define HSD_ADDR_OCR     4'h3
`define HSD_ADDR_FAULT0  4'h4
`define HSD_ADDR_FAULT1  4'h5
`define HSD_ADDR_STAT    4'h6

// ****************************************
// field positions and reset values
// ****************************************
`define HSD_CONF_DIRDIS  5
`define HSD_CONF_OSDIS   6
`define HSD_CONF_OFFDIS  7
`define HSD_CONF_ONDIS   8
`define HSD_CONF_FAST    0
`define HSD_CONF_INTPWM  1
`define HSD_CONF_MOTOR   2
`define HSD_GCR_SEL0     0
`define HSD_GCR_SEL1     1
`define HSD_GCR_TH       2
`define HSD_OCR_LOWRAT   0
`define HSD_FLT_OS       0
`define HSD_FLT_OFF      1
`define HSD_FLT_ON       2
`define HSD_CONF_RST     16'h0000
`define HSD_GCR_RST      16'h0000
`define HSD_OCR_RST      16'h0000

// ****************************************
// timing
// ****************************************
`define HSD_CLK_HZ       50000000
`define HSD_OLLED_MS     150
`define HSD_OLLED_CYC    ((`HSD_CLK_HZ / 1000) * `HSD_OLLED_MS)
`define HSD_SETTLE_US    10
`define HSD_SETTLE_CYC   ((`HSD_CLK_HZ / 1000000) * `HSD_SETTLE_US)

`endif

// ### hsd_pkg.sv
// hsd_pkg.sv : types shared by the diagnostic block
// assumes hsd_map.svh is on the include path
`include "hsd_map.svh"
package hsd_pkg;
  typedef logic [15:0] hsd_word_t;
  typedef logic [9:0]  hsd_sense_t;
  typedef enum logic [1:0] {
    HSD_SNS_OFF,
    HSD_SNS_SETTLE,
    HSD_SNS_VALID
  } hsd_sns_state_t;
endpackage

// ### hsd_chan.sv
// hsd_chan.sv : per-channel fault latching and open-load-on scheduling
// assumes inputs synchronous to clock, one-cycle read pulse
`timescale 1ns/10ps
`include "hsd_map.svh"
module hsd_chan
  import hsd_pkg::*;
#(
  parameter int unsigned OLLED_CYC = `HSD_OLLED_CYC
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_sync_n,
  // channel state and analog comparators
  input  wire logic       chan_on,
  input  wire logic       os_cmp,
  input  wire logic       olf_cmp,
  input  wire logic       oln_cmp,
  // configuration
  input  wire hsd_word_t  conf,
  input  wire logic       low_ratio,
  // software read of this fault register
  input  wire logic       fault_rd,
  // results
  output logic [2:0]      fault_reg,
  output logic            live_fault
);
  logic        on_d_reg;
  logic [31:0] per_cnt_reg;
  logic        clean_reg;
  logic        off_edge;
  logic        per_due;
  logic        ln_chk;
  logic        os_live;
  logic        off_live;
  logic        on_live;
  logic        oln_d_reg;
  logic        oln_seen;

  assign off_edge = on_d_reg & ~chan_on;
  assign per_due  = per_cnt_reg >= OLLED_CYC;
  // at an off edge the comparator already sees a dead output, so the
  // check uses the level from the last on cycle instead
  assign oln_seen = chan_on ? oln_cmp : oln_d_reg;

  // low-ratio check instant; direct input only checks on a real off edge
  always_comb begin
    if (conf[`HSD_CONF_INTPWM] || conf[`HSD_CONF_DIRDIS])
      ln_chk = per_due & (off_edge | chan_on);
    else
      ln_chk = off_edge;
    ln_chk = ln_chk & conf[`HSD_CONF_FAST] & low_ratio;
  end

  // live detections, each gated by its disable bit
  assign os_live  = ~chan_on & os_cmp & ~conf[`HSD_CONF_OSDIS];
  assign off_live = ~chan_on & olf_cmp & ~conf[`HSD_CONF_OFFDIS];
  assign on_live  = ~conf[`HSD_CONF_ONDIS] & oln_seen &
                    (low_ratio ? ln_chk : chan_on);
  assign live_fault = os_live | off_live |
                      (on_live & ~low_ratio);

  // edge tracking and 150 ms period counter
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      on_d_reg    <= 1'b0;
      oln_d_reg   <= 1'b0;
      per_cnt_reg <= 32'h0;
    end else begin
      on_d_reg  <= chan_on;
      oln_d_reg <= oln_cmp;
      if (ln_chk)
        per_cnt_reg <= 32'h0;
      else if (!per_due)
        per_cnt_reg <= per_cnt_reg + 32'h1;
    end
  end

  // sticky fault bits; a new detection beats the read clear
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fault_reg <= 3'h0;
      clean_reg <= 1'b0;
    end else begin
      if (ln_chk)
        clean_reg <= ~oln_seen;
      else if (fault_rd)
        clean_reg <= 1'b0;
      if (os_live)
        fault_reg[`HSD_FLT_OS] <= 1'b1;
      else if (fault_rd)
        fault_reg[`HSD_FLT_OS] <= 1'b0;
      if (off_live)
        fault_reg[`HSD_FLT_OFF] <= 1'b1;
      else if (fault_rd)
        fault_reg[`HSD_FLT_OFF] <= 1'b0;
      if (on_live)
        fault_reg[`HSD_FLT_ON] <= 1'b1;
      else if (fault_rd && low_ratio && clean_reg)
        fault_reg[`HSD_FLT_ON] <= 1'b0;
      else if (fault_rd && !low_ratio && (!chan_on || !oln_cmp))
        fault_reg[`HSD_FLT_ON] <= 1'b0;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_os_sets;
    @(posedge clock) disable iff (!rst_sync_n)
      os_live |=> fault_reg[`HSD_FLT_OS];
  endproperty
  a_os_sets: assert property (p_os_sets)
    else $error("short fault bit not set");

  property p_os_only_off;
    @(posedge clock) disable iff (!rst_sync_n)
      chan_on |-> !os_live;
  endproperty
  a_os_only_off: assert property (p_os_only_off)
    else $error("short detected while on");

  property p_os_hold;
    @(posedge clock) disable iff (!rst_sync_n)
      fault_reg[`HSD_FLT_OS] && !fault_rd |=> fault_reg[`HSD_FLT_OS];
  endproperty
  a_os_hold: assert property (p_os_hold)
    else $error("short bit cleared without read");

  property p_off_hold;
    @(posedge clock) disable iff (!rst_sync_n)
      fault_reg[`HSD_FLT_OFF] && !fault_rd |=> fault_reg[`HSD_FLT_OFF];
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("open-load-off bit cleared without read");

  property p_dis;
    @(posedge clock) disable iff (!rst_sync_n)
      conf[`HSD_CONF_OSDIS] && conf[`HSD_CONF_OFFDIS] &&
      conf[`HSD_CONF_ONDIS] |-> !live_fault;
  endproperty
  a_dis: assert property (p_dis)
    else $error("fault pin with detection disabled");

  property p_slow;
    @(posedge clock) disable iff (!rst_sync_n)
      low_ratio && !conf[`HSD_CONF_FAST] |-> !ln_chk;
  endproperty
  a_slow: assert property (p_slow)
    else $error("low ratio check with slow slew");
endmodule // hsd_chan

// ### hsd_diag.sv
// hsd_diag.sv : diagnostics and current-sense control for two channels
// assumes synchronous inputs and a one-cycle-latency register port
`timescale 1ns/10ps
`include "hsd_map.svh"
module hsd_diag
  import hsd_pkg::*;
#(
  parameter int unsigned OLLED_CYC = `HSD_OLLED_CYC
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire hsd_word_t   reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output hsd_word_t        reg_rdata,
  // channel status and retry events
  input  wire logic [1:0]  chan_on,
  input  wire logic [1:0]  retry_evt,
  input  wire logic [1:0]  oc_now,
  // analog comparators
  input  wire logic [1:0]  os_cmp,
  input  wire logic [1:0]  olf_cmp,
  input  wire logic [1:0]  oln_cmp,
  // sense sources
  input  wire hsd_sense_t  cur0,
  input  wire hsd_sense_t  cur1,
  input  wire hsd_sense_t  temp,
  // outputs
  output logic             fault_flag_out_n,
  output logic             sense_valid_n,
  output hsd_sense_t       sense_out,
  output logic             oc_low_thresh,
  output logic [1:0]       oc_dur_clr
);
  logic           rs1_reg;
  logic           rst_sync_n;
  hsd_word_t      conf_reg [2];
  hsd_word_t      gcr_reg;
  hsd_word_t      ocr_reg;
  logic [2:0]     fault_w  [2];
  logic [1:0]     live_w;
  logic [1:0]     on_d_reg;
  logic [1:0]     clean_per_reg;
  logic [1:0]     off_edge;
  hsd_sns_state_t sns_reg;
  logic [15:0]    settle_reg;
  hsd_sense_t     hold_reg;
  hsd_sense_t     sel_cur;
  logic           sel_on;
  logic           sel_ch;

  // ****************************************
  // reset release
  // ****************************************
  // two stages so release never races the clock edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rs1_reg    <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rs1_reg    <= 1'b1;
      rst_sync_n <= rs1_reg;
    end
  end

  // ****************************************
  // register port
  // ****************************************
  function automatic logic is_addr(input logic [3:0] a, input logic [3:0] b);
    return a == b;
  endfunction

  // configuration writes
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      conf_reg[0] <= `HSD_CONF_RST;
      conf_reg[1] <= `HSD_CONF_RST;
      gcr_reg     <= `HSD_GCR_RST;
      ocr_reg     <= `HSD_OCR_RST;
    end else if (reg_wr) begin
      if (is_addr(reg_addr, `HSD_ADDR_CONF0)) conf_reg[0] <= reg_wdata;
      if (is_addr(reg_addr, `HSD_ADDR_CONF1)) conf_reg[1] <= reg_wdata;
      if (is_addr(reg_addr, `HSD_ADDR_GCR))   gcr_reg     <= reg_wdata;
      if (is_addr(reg_addr, `HSD_ADDR_OCR))   ocr_reg     <= reg_wdata;
    end
  end

  // read data one cycle after the strobe, zero for unmapped offsets
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n)
      reg_rdata <= 16'h0;
    else if (reg_rd) begin
      case (reg_addr)
        `HSD_ADDR_CONF0:  reg_rdata <= conf_reg[0];
        `HSD_ADDR_CONF1:  reg_rdata <= conf_reg[1];
        `HSD_ADDR_GCR:    reg_rdata <= gcr_reg;
        `HSD_ADDR_OCR:    reg_rdata <= ocr_reg;
        `HSD_ADDR_FAULT0: reg_rdata <= {13'h0, fault_w[0]};
        `HSD_ADDR_FAULT1: reg_rdata <= {13'h0, fault_w[1]};
        `HSD_ADDR_STAT:   reg_rdata <= {12'h0, live_w, chan_on};
        default:          reg_rdata <= 16'h0;
      endcase
    end else
      reg_rdata <= 16'h0;
  end

  // ****************************************
  // per-channel diagnostics
  // ****************************************
  for (genvar c = 0; c < 2; c++) begin : g_ch
    hsd_chan #(
      .OLLED_CYC (OLLED_CYC)
    ) u_chan (
      .clock      (clock),
      .rst_sync_n (rst_sync_n),
      .chan_on    (chan_on[c]),
      .os_cmp     (os_cmp[c]),
      .olf_cmp    (olf_cmp[c]),
      .oln_cmp    (oln_cmp[c]),
      .conf       (conf_reg[c]),
      .low_ratio  (ocr_reg[`HSD_OCR_LOWRAT]),
      .fault_rd   (reg_rd & is_addr(reg_addr, 4'(`HSD_ADDR_FAULT0 + c))),
      .fault_reg  (fault_w[c]),
      .live_fault (live_w[c])
    );
  end

  // fault pin only follows live conditions, never turns channels off
  assign fault_flag_out_n = ~|live_w;

  // ****************************************
  // overcurrent duration counter clear
  // ****************************************
  assign off_edge = on_d_reg & ~chan_on;

  // track whether the present on period stayed free of overcurrent
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      on_d_reg      <= 2'h0;
      clean_per_reg <= 2'h3;
    end else begin
      on_d_reg <= chan_on;
      for (int i = 0; i < 2; i++) begin
        if (oc_now[i])
          clean_per_reg[i] <= 1'b0;
        else if (off_edge[i])
          clean_per_reg[i] <= 1'b1;
      end
    end
  end

  // lighting clears at each retry, motor at first clean off edge
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (conf_reg[i][`HSD_CONF_MOTOR])
        oc_dur_clr[i] = off_edge[i] & clean_per_reg[i] & ~oc_now[i];
      else
        oc_dur_clr[i] = retry_evt[i];
    end
  end

  assign oc_low_thresh = ocr_reg[`HSD_OCR_LOWRAT];

  // ****************************************
  // current sense
  // ****************************************
  assign sel_ch  = gcr_reg[`HSD_GCR_SEL1];
  assign sel_on  = chan_on[sel_ch];
  assign sel_cur = sel_ch ? cur1 : cur0;

  // settle timer and sense-valid state
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sns_reg    <= HSD_SNS_OFF;
      settle_reg <= 16'h0;
    end else begin
      case (sns_reg)
        HSD_SNS_OFF: begin
          settle_reg <= 16'h0;
          if (sel_on) sns_reg <= HSD_SNS_SETTLE;
        end
        HSD_SNS_SETTLE: begin
          settle_reg <= settle_reg + 16'h1;
          if (!sel_on)
            sns_reg <= HSD_SNS_OFF;
          else if (settle_reg == 16'(`HSD_SETTLE_CYC - 1))
            sns_reg <= HSD_SNS_VALID;
        end
        HSD_SNS_VALID: begin
          if (!sel_on) sns_reg <= HSD_SNS_OFF;
        end
        default: sns_reg <= HSD_SNS_OFF;
      endcase
    end
  end

  // sample while tracking, freeze at switch-off
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n)
      hold_reg <= 10'h0;
    else if (sel_on)
      hold_reg <= sel_cur;
  end

  assign sense_valid_n = ~(sns_reg == HSD_SNS_VALID);

  // output mux: temperature, live current, held or nothing
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n)
      sense_out <= 10'h0;
    else if (gcr_reg[`HSD_GCR_SEL0] && gcr_reg[`HSD_GCR_SEL1])
      sense_out <= temp;
    else if (!(gcr_reg[`HSD_GCR_SEL0] ^ gcr_reg[`HSD_GCR_SEL1]))
      sense_out <= 10'h0;
    else if (sel_on)
      sense_out <= sel_cur;
    else if (gcr_reg[`HSD_GCR_TH])
      sense_out <= hold_reg;
    else
      sense_out <= 10'h0;
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_light_clr;
    @(posedge clock) disable iff (!rst_sync_n)
      retry_evt[0] && !conf_reg[0][`HSD_CONF_MOTOR] |-> oc_dur_clr[0];
  endproperty
  a_light_clr: assert property (p_light_clr)
    else $error("lighting retry did not clear duration");

  property p_motor_clr;
    @(posedge clock) disable iff (!rst_sync_n)
      conf_reg[0][`HSD_CONF_MOTOR] && oc_dur_clr[0] |-> !chan_on[0];
  endproperty
  a_motor_clr: assert property (p_motor_clr)
    else $error("motor clear outside off edge");

  property p_sync_off;
    @(posedge clock) disable iff (!rst_sync_n)
      !gcr_reg[`HSD_GCR_TH] && (gcr_reg[1:0] == 2'h1) && !chan_on[0]
      ##1 !chan_on[0] && $stable(gcr_reg) |-> sense_out == 10'h0;
  endproperty
  a_sync_off: assert property (p_sync_off)
    else $error("sense current after turn-off in sync mode");

  property p_valid_off;
    @(posedge clock) disable iff (!rst_sync_n)
      !sel_on |=> sense_valid_n;
  endproperty
  a_valid_off: assert property (p_valid_off)
    else $error("sense valid held after switch-off");

  property p_ratio;
    @(posedge clock) disable iff (!rst_sync_n)
      reg_wr && is_addr(reg_addr, `HSD_ADDR_OCR) |=>
      oc_low_thresh == $past(reg_wdata[`HSD_OCR_LOWRAT]);
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("low threshold does not follow ratio");

  // configuration and fault read-back
  property p_conf_wr;
    @(posedge clock) disable iff (!rst_sync_n)
      reg_wr && is_addr(reg_addr, `HSD_ADDR_CONF0) |=>
      conf_reg[0] == $past(reg_wdata);
  endproperty
  a_conf_wr: assert property (p_conf_wr)
    else $error("configuration write lost");

  property p_fault_rd;
    @(posedge clock) disable iff (!rst_sync_n)
      reg_rd && is_addr(reg_addr, `HSD_ADDR_FAULT0) |=>
      reg_rdata == {13'h0, $past(fault_w[0])};
  endproperty
  a_fault_rd: assert property (p_fault_rd)
    else $error("fault register read-back wrong");

  // duration clear only where the profile allows it
  property p_motor_oc;
    @(posedge clock) disable iff (!rst_sync_n)
      conf_reg[0][`HSD_CONF_MOTOR] && oc_now[0] |-> !oc_dur_clr[0];
  endproperty
  a_motor_oc: assert property (p_motor_oc)
    else $error("motor clear during overcurrent");

  property p_light_quiet;
    @(posedge clock) disable iff (!rst_sync_n)
      !conf_reg[0][`HSD_CONF_MOTOR] && !retry_evt[0] |-> !oc_dur_clr[0];
  endproperty
  a_light_quiet: assert property (p_light_quiet)
    else $error("lighting clear without retry");

  // sense routing
  property p_temp;
    @(posedge clock) disable iff (!rst_sync_n)
      gcr_reg[1:0] == 2'h3 |=> sense_out == $past(temp);
  endproperty
  a_temp: assert property (p_temp)
    else $error("temperature not routed");

  property p_none;
    @(posedge clock) disable iff (!rst_sync_n)
      gcr_reg[1:0] == 2'h0 |=> sense_out == 10'h0;
  endproperty
  a_none: assert property (p_none)
    else $error("sense output without selection");

  property p_sync_on;
    @(posedge clock) disable iff (!rst_sync_n)
      gcr_reg[1:0] == 2'h1 && chan_on[0] |=> sense_out == $past(cur0);
  endproperty
  a_sync_on: assert property (p_sync_on)
    else $error("channel 0 current not routed");

  property p_th_capture;
    @(posedge clock) disable iff (!rst_sync_n)
      gcr_reg[2:0] == 3'h5 && chan_on[0]
      ##1 gcr_reg[2:0] == 3'h5 && !chan_on[0] |=>
      sense_out == $past(cur0, 2);
  endproperty
  a_th_capture: assert property (p_th_capture)
    else $error("held sample is not the pre-off value");

  // sense-valid timing
  property p_valid_rise;
    @(posedge clock) disable iff (!rst_sync_n)
      $fell(sense_valid_n) |-> settle_reg == 16'(`HSD_SETTLE_CYC);
  endproperty
  a_valid_rise: assert property (p_valid_rise)
    else $error("sense valid before settling time");

  property p_valid_hold;
    @(posedge clock) disable iff (!rst_sync_n)
      !sense_valid_n && sel_on |=> !sense_valid_n;
  endproperty
  a_valid_hold: assert property (p_valid_hold)
    else $error("sense valid dropped while on");
endmodule // hsd_diag

// ### hsd_load_model.sv
// hsd_load_model.sv : loads and output comparators on both channels
// assumes the bench sets channel state and fault knobs after clock edges
`timescale 1ns/10ps
module hsd_load_model
  import hsd_pkg::*;
#(
  parameter hsd_sense_t LOAD0 = 10'h155,
  parameter hsd_sense_t LOAD1 = 10'h0aa,
  parameter hsd_sense_t TEMPV = 10'h1c3
) (
  // channel state and injected faults
  input  wire logic [1:0] chan_on,
  input  wire logic [1:0] open_load,
  input  wire logic [1:0] short_sup,
  // comparators and sense sources
  output logic [1:0]      os_cmp,
  output logic [1:0]      olf_cmp,
  output logic [1:0]      oln_cmp,
  output hsd_sense_t      cur0,
  output hsd_sense_t      cur1,
  output hsd_sense_t      temp
);
  // ****************************************
  // comparators
  // ****************************************
  // an on switch pulls the output to supply, so both voltage
  // comparators trip while on; the block must mask them itself
  assign os_cmp  = chan_on | short_sup;
  assign olf_cmp = chan_on | open_load;
  // no current flows while off, so the under-current comparator trips
  assign oln_cmp = ~chan_on | open_load;
  // load current only with the switch on and the load present
  assign cur0 = (chan_on[0] & ~open_load[0]) ? LOAD0 : 10'h000;
  assign cur1 = (chan_on[1] & ~open_load[1]) ? LOAD1 : 10'h000;
  assign temp = TEMPV;
endmodule // hsd_load_model

// ### tb_hsd_diag.sv
// tb_hsd_diag.sv : self-checking bench for diagnostics and sensing
// assumes hsd_pkg, hsd_chan, hsd_diag and hsd_load_model compiled first
`timescale 1ns/10ps
module tb_hsd_diag;
  import hsd_pkg::*;
  // short open-load period keeps the run brief
  localparam int unsigned OLLED = 50;
  localparam hsd_sense_t  LOAD0 = 10'h155;
  localparam hsd_sense_t  LOAD1 = 10'h0aa;
  localparam hsd_sense_t  TEMPV = 10'h1c3;
  localparam int          LIMIT = 20000;
  logic        clock, rst_n, reg_wr, reg_rd;
  logic [3:0]  reg_addr;
  hsd_word_t   reg_wdata, reg_rdata;
  logic [1:0]  chan_on, retry_evt, oc_now, open_load, short_sup;
  logic [1:0]  os_cmp, olf_cmp, oln_cmp, oc_dur_clr;
  hsd_sense_t  cur0, cur1, temp, sense_out;
  logic        fault_flag_out_n, sense_valid_n, oc_low_thresh;
  int          error_cnt, compares, cycles, clr_cnt, n0;

  hsd_diag #(.OLLED_CYC(OLLED)) DUT (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .chan_on(chan_on), .retry_evt(retry_evt),
    .oc_now(oc_now), .os_cmp(os_cmp), .olf_cmp(olf_cmp),
    .oln_cmp(oln_cmp), .cur0(cur0), .cur1(cur1), .temp(temp),
    .fault_flag_out_n(fault_flag_out_n), .sense_valid_n(sense_valid_n),
    .sense_out(sense_out), .oc_low_thresh(oc_low_thresh),
    .oc_dur_clr(oc_dur_clr));
  hsd_load_model #(.LOAD0(LOAD0), .LOAD1(LOAD1), .TEMPV(TEMPV)) u_load (
    .chan_on(chan_on), .open_load(open_load), .short_sup(short_sup),
    .os_cmp(os_cmp), .olf_cmp(olf_cmp), .oln_cmp(oln_cmp),
    .cur0(cur0), .cur1(cur1), .temp(temp));

  // ****************************************
  // clock, watchdog and shared tasks
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // counting clear pulses avoids guessing their exact cycle
  always @(posedge clock) begin
    cycles++;
    clr_cnt += int'(oc_dur_clr[0] === 1'b1);
    if (cycles == LIMIT) begin
      error_cnt++;
      $display("mismatch watchdog expected done seen %0d cycles", cycles);
      finish_test();
    end
  end
  task automatic chk(input string what, input hsd_word_t exp,
                     input hsd_word_t got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input hsd_word_t d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input string what, input logic [3:0] a,
                    input hsd_word_t exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask
  task automatic drive(input logic [1:0] on, input logic [1:0] ol,
                       input logic [1:0] ss, input int n);
    @(posedge clock);
    chan_on   <= on;
    open_load <= ol;
    short_sup <= ss;
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic period(input logic oc);
    @(posedge clock);
    chan_on <= 2'h1;
    oc_now  <= {1'b0, oc};
    repeat (10) @(posedge clock);
    chan_on <= 2'h0;
    oc_now  <= 2'h0;
    repeat (10) @(posedge clock);
  endtask
  task automatic retry();
    @(posedge clock);
    retry_evt <= 2'h1;
    @(posedge clock);
    retry_evt <= 2'h0;
    repeat (3) @(posedge clock);
  endtask
  task automatic finish_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {chan_on, retry_evt, oc_now, open_load, short_sup} = '0;
    {error_cnt, compares, cycles, clr_cnt} = '0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    // reset values, unmapped place and read-only fault register
    rd("conf0", 4'h0, 16'h0000);
    rd("gcr", 4'h2, 16'h0000);
    rd("ocr", 4'h3, 16'h0000);
    rd("unmapped", 4'hf, 16'h0000);
    wr(4'h4, 16'h0007);
    rd("fault0 ro", 4'h4, 16'h0000);
    $display("test reset_values done");
    // short to supply while off, then the same with detection off
    drive(2'h0, 2'h0, 2'h1, 3);
    chk("flag short", 16'h0000, fault_flag_out_n);
    drive(2'h0, 2'h0, 2'h0, 3);
    chk("flag short gone", 16'h0001, fault_flag_out_n);
    rd("fault0 short", 4'h4, 16'h0001);
    rd("fault0 cleared", 4'h4, 16'h0000);
    wr(4'h0, 16'h0040);
    drive(2'h0, 2'h0, 2'h1, 3);
    chk("flag short dis", 16'h0001, fault_flag_out_n);
    rd("fault0 short dis", 4'h4, 16'h0000);
    // remove the short first, or re-enabling latches it again
    drive(2'h0, 2'h0, 2'h0, 1);
    wr(4'h0, 16'h0000);
    $display("test short done");
    // open load while off
    drive(2'h0, 2'h1, 2'h0, 3);
    chk("flag open off", 16'h0000, fault_flag_out_n);
    drive(2'h0, 2'h0, 2'h0, 2);
    chk("flag open off gone", 16'h0001, fault_flag_out_n);
    rd("fault0 open off", 4'h4, 16'h0002);
    rd("fault0 open off clr", 4'h4, 16'h0000);
    // healthy on state: voltage comparators high must be ignored
    drive(2'h1, 2'h0, 2'h0, 3);
    chk("flag on clean", 16'h0001, fault_flag_out_n);
    rd("fault0 on clean", 4'h4, 16'h0000);
    // open load while on, high ratio
    drive(2'h1, 2'h1, 2'h0, 3);
    chk("flag open on", 16'h0000, fault_flag_out_n);
    rd("fault0 open on", 4'h4, 16'h0004);
    rd("fault0 cause kept", 4'h4, 16'h0004);
    drive(2'h1, 2'h0, 2'h0, 3);
    chk("flag open on gone", 16'h0001, fault_flag_out_n);
    rd("fault0 gone", 4'h4, 16'h0004);
    rd("fault0 gone clr", 4'h4, 16'h0000);
    drive(2'h1, 2'h1, 2'h0, 3);
    wr(4'h0, 16'h00c0);
    drive(2'h0, 2'h1, 2'h0, 3);
    rd("fault0 off read", 4'h4, 16'h0004);
    rd("fault0 off clr", 4'h4, 16'h0000);
    drive(2'h0, 2'h0, 2'h0, 3);
    $display("test open_load done");
    // duration counter clearing, lighting then motor
    n0 = clr_cnt;
    retry();
    chk("clr lighting", 16'(n0 + 1), 16'(clr_cnt));
    wr(4'h0, 16'h00c4);
    n0 = clr_cnt;
    retry();
    period(1'b1);
    chk("clr motor oc", 16'(n0), 16'(clr_cnt));
    period(1'b0);
    chk("clr motor clean", 16'(n0 + 1), 16'(clr_cnt));
    $display("test duration done");
    // low ratio, internal pwm at full duty
    wr(4'h3, 16'h0001);
    #1;
    chk("low thresh", 16'h0001, oc_low_thresh);
    wr(4'h0, 16'h00c3);
    drive(2'h1, 2'h1, 2'h0, 3 * OLLED);
    chk("flag low ratio", 16'h0001, fault_flag_out_n);
    rd("fault0 low set", 4'h4, 16'h0004);
    rd("fault0 low kept", 4'h4, 16'h0004);
    drive(2'h1, 2'h0, 2'h0, 3 * OLLED);
    rd("fault0 low clean", 4'h4, 16'h0004);
    rd("fault0 low clr", 4'h4, 16'h0000);
    // slow slew gives no check; direct input checks at off edges only
    wr(4'h0, 16'h00c2);
    drive(2'h1, 2'h1, 2'h0, 3 * OLLED);
    rd("fault0 slow slew", 4'h4, 16'h0000);
    wr(4'h0, 16'h00c1);
    drive(2'h1, 2'h1, 2'h0, 3 * OLLED);
    rd("fault0 direct full", 4'h4, 16'h0000);
    drive(2'h0, 2'h1, 2'h0, 3);
    rd("fault0 direct edge", 4'h4, 16'h0004);
    // a healthy load must not trip at the off edge
    drive(2'h1, 2'h0, 2'h0, 3);
    drive(2'h0, 2'h0, 2'h0, 3);
    rd("fault0 direct clean", 4'h4, 16'h0004);
    rd("fault0 direct clr", 4'h4, 16'h0000);
    // direct input disabled restores the check at full duty
    wr(4'h0, 16'h00e1);
    drive(2'h1, 2'h1, 2'h0, 3 * OLLED);
    rd("fault0 dir dis", 4'h4, 16'h0004);
    drive(2'h0, 2'h0, 2'h0, 1);
    wr(4'h3, 16'h0000);
    $display("test low_ratio done");
    // synchronous sensing of channel 0
    wr(4'h2, 16'h0001);
    drive(2'h1, 2'h0, 2'h0, 100);
    chk("valid early", 16'h0001, sense_valid_n);
    drive(2'h1, 2'h0, 2'h0, 450);
    chk("valid sync", 16'h0000, sense_valid_n);
    chk("sense ch0", 16'(LOAD0), 16'(sense_out));
    drive(2'h0, 2'h0, 2'h0, 3);
    chk("valid sync off", 16'h0001, sense_valid_n);
    chk("sense sync off", 16'h0000, 16'(sense_out));
    // track and hold keeps the pre-off sample
    wr(4'h2, 16'h0005);
    drive(2'h1, 2'h0, 2'h0, 550);
    chk("valid th", 16'h0000, sense_valid_n);
    drive(2'h0, 2'h0, 2'h0, 3);
    chk("valid th off", 16'h0001, sense_valid_n);
    chk("sense th hold", 16'(LOAD0), 16'(sense_out));
    // temperature and channel 1 routing
    wr(4'h2, 16'h0003);
    drive(2'h0, 2'h0, 2'h0, 3);
    chk("sense temp", 16'(TEMPV), 16'(sense_out));
    wr(4'h2, 16'h0002);
    drive(2'h2, 2'h0, 2'h0, 550);
    chk("sense ch1", 16'(LOAD1), 16'(sense_out));
    $display("test sensing done");
    finish_test();
  end
endmodule // tb_hsd_diag
